// ### common/lilc_params.svh
// How it works
// - Each input's three-bit function code picks its role: 1 holds the length and 4 resets the length.
// - Each input's polarity bit makes it active on a low level when 0 and on a high level when 1.
// - The input configuration word holds four bits per input at bits 0-3, 4-7 and 8-11, with the function code low and the polarity bit on top.
// - A length reset input kept active for five seconds also clears the reel count.
// - An unconnected input reads high because of its pull-up.
// - The length offset word is signed, counts tenths of the length unit and spans plus or minus 3000.0 units.
// - A factory option switches the offset step to thousandths of the length unit.
// - While any length hold input is active the length freezes unless a reset input is active, and the reported speed is zero, though speed is still measured.
// - The programmed offset is added to the length that is output.
`ifndef LILC_PARAMS_SVH
`define LILC_PARAMS_SVH

`define LILC_CLK_HZ 40000000
`define LILC_ADDR_W 8
`define LILC_DATA_W 16
`define LILC_ADDR_INPUT_CFG 8'h0C
`define LILC_ADDR_LEN_OFFSET 8'h0E
`define LILC_INPUT_CFG_RESET 16'h0000
`define LILC_LEN_OFFSET_RESET 16'h0000
`define LILC_INPUT_CFG_MASK 16'h0FFF
`define LILC_FIELD_W 4
`define LILC_FUNC_W 3
`define LILC_POL_BIT 3
`define LILC_NUM_INPUTS 3
`define LILC_OFFSET_MAX 16'sd30000
`define LILC_OFFSET_MIN (-16'sd30000)
`define LILC_COARSE_SCALE 32'sd100
`define LILC_LEN_W 32
`define LILC_REEL_HOLD_S 5
`define LILC_REEL_HOLD_CYC (`LILC_REEL_HOLD_S * `LILC_CLK_HZ)

`endif

// ### common/lilc_pkg.sv
package lilc_pkg;
   typedef enum logic [2:0]
   {
      LILC_FN_NONE = 3'h0,
      LILC_FN_HOLD = 3'h1,
      LILC_FN_RESET = 3'h4
   } lilc_func_e;
   typedef logic [15:0] lilc_word_t;
   typedef logic signed [31:0] lilc_len_t;
endpackage

// ### core/lilc_input_cond.sv
`timescale 1ns/1ps
`default_nettype none
module lilc_input_cond
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin,
   input wire logic pol,
   output logic active
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic level_reg;

   // reset to high, as an open pin would read
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
      end
      else
      begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // a change counts only once two stages agree
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         level_reg <= 1'b1;
      else if (s2_reg == s3_reg)
         level_reg <= s3_reg;
   end

   assign active = (level_reg == pol);
endmodule
`default_nettype wire

// ### core/lilc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "lilc_params.svh"
module lilc_top
#(
   parameter int unsigned REEL_HOLD_CYCLES = `LILC_REEL_HOLD_CYC,
   parameter bit FINE_OFFSET = 1'b0
)
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic FIRST_DIGITAL_IN,
   input wire logic SECOND_DIGITAL_IN,
   input wire logic THIRD_DIGITAL_IN,
   input wire logic CFG_WR,
   input wire logic CFG_RD,
   input wire logic [`LILC_ADDR_W-1:0] CFG_ADDR,
   input wire lilc_pkg::lilc_word_t CFG_WDATA,
   output lilc_pkg::lilc_word_t CFG_RDATA,
   output logic CFG_ACK,
   output logic CFG_ERR,
   input wire logic LEN_STEP,
   input wire logic LEN_STEP_DOWN,
   input wire logic [15:0] SPEED_IN,
   output logic [15:0] SPEED_OUT,
   output lilc_pkg::lilc_len_t LENGTH_OUT,
   output logic HOLD_ACTIVE,
   output logic RESET_ACTIVE,
   output logic REEL_CLEAR
);
   import lilc_pkg::*;

   lilc_word_t input_config_word_reg;
   lilc_word_t length_offset_word_reg;
   lilc_len_t length_acc_reg;
   logic [31:0] reel_cnt_reg;
   logic reel_done_reg;
   logic [`LILC_NUM_INPUTS-1:0] pins;
   logic [`LILC_NUM_INPUTS-1:0] act;
   logic [`LILC_NUM_INPUTS-1:0] is_hold;
   logic [`LILC_NUM_INPUTS-1:0] is_reset;
   logic hold_any;
   logic reset_any;
   logic signed [15:0] wr_off;
   logic signed [15:0] off_clamped;
   lilc_len_t offset_scaled;

   assign pins = {THIRD_DIGITAL_IN, SECOND_DIGITAL_IN, FIRST_DIGITAL_IN};

   genvar gi;
   generate
      for (gi = 0; gi < `LILC_NUM_INPUTS; gi = gi + 1)
      begin : g_in
         lilc_func_e fn;
         // field layout: code low, polarity on top
         assign fn = lilc_func_e'(input_config_word_reg[
            gi*`LILC_FIELD_W +: `LILC_FUNC_W]);
         lilc_input_cond u_cond
         (
            .clk(CLK),
            .rst_n(RST_N),
            .pin(pins[gi]),
            .pol(input_config_word_reg[
               gi*`LILC_FIELD_W + `LILC_POL_BIT]),
            .active(act[gi])
         );
         // other codes fall out of both terms
         assign is_hold[gi] = act[gi] &&
            (fn == LILC_FN_HOLD);
         assign is_reset[gi] = act[gi] &&
            (fn == LILC_FN_RESET);
      end
   endgenerate

   assign hold_any = |is_hold;
   assign reset_any = |is_reset;

   // coarse-step offsets beyond plus or minus 30000 saturate instead of wrapping; fine-step offsets are stored unclamped
   assign wr_off = signed'(CFG_WDATA);
   always_comb
   begin
      off_clamped = wr_off;
      if (!FINE_OFFSET)
      begin
         if (wr_off > `LILC_OFFSET_MAX)
            off_clamped = `LILC_OFFSET_MAX;
         else if (wr_off < `LILC_OFFSET_MIN)
            off_clamped = `LILC_OFFSET_MIN;
      end
   end

   // configuration word writes
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         input_config_word_reg <= `LILC_INPUT_CFG_RESET;
         length_offset_word_reg <= `LILC_LEN_OFFSET_RESET;
      end
      else if (CFG_WR)
      begin
         if (CFG_ADDR == `LILC_ADDR_INPUT_CFG)
            input_config_word_reg <=
               CFG_WDATA & `LILC_INPUT_CFG_MASK;
         else if (CFG_ADDR == `LILC_ADDR_LEN_OFFSET)
            length_offset_word_reg <= lilc_word_t'(off_clamped);
      end
   end

   // read-back and access answer, one cycle after the strobe
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         CFG_RDATA <= 16'h0000;
         CFG_ACK <= 1'b0;
         CFG_ERR <= 1'b0;
      end
      else
      begin
         CFG_ACK <= CFG_WR | CFG_RD;
         CFG_ERR <= (CFG_WR | CFG_RD) &&
            (CFG_ADDR != `LILC_ADDR_INPUT_CFG) &&
            (CFG_ADDR != `LILC_ADDR_LEN_OFFSET);
         if (CFG_RD && CFG_ADDR == `LILC_ADDR_INPUT_CFG)
            CFG_RDATA <= input_config_word_reg;
         else if (CFG_RD && CFG_ADDR == `LILC_ADDR_LEN_OFFSET)
            CFG_RDATA <= length_offset_word_reg;
         else
            CFG_RDATA <= 16'h0000;
      end
   end

   // length kept in thousandths; reset beats hold
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
         length_acc_reg <= '0;
      else if (reset_any)
         length_acc_reg <= '0;
      else if (!hold_any)
      begin
         if (LEN_STEP && !LEN_STEP_DOWN)
            length_acc_reg <= length_acc_reg + 32'sd1;
         else if (LEN_STEP && LEN_STEP_DOWN)
            length_acc_reg <= length_acc_reg - 32'sd1;
      end
      // frozen while held
   end

   // coarse step is a hundred fine steps
   assign offset_scaled = FINE_OFFSET ?
      lilc_len_t'(signed'(length_offset_word_reg)) :
      lilc_len_t'(signed'(length_offset_word_reg)) *
         `LILC_COARSE_SCALE;

   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         LENGTH_OUT <= '0;
         SPEED_OUT <= 16'h0000;
         HOLD_ACTIVE <= 1'b0;
         RESET_ACTIVE <= 1'b0;
      end
      else
      begin
         LENGTH_OUT <= length_acc_reg + offset_scaled;
         // speed still tracked upstream, only reporting is gated
         SPEED_OUT <= hold_any ? 16'h0000 : SPEED_IN;
         HOLD_ACTIVE <= hold_any;
         RESET_ACTIVE <= reset_any;
      end
   end

   // long reset hold: one reel clear per continuous hold
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         reel_cnt_reg <= 32'h0000_0000;
         reel_done_reg <= 1'b0;
         REEL_CLEAR <= 1'b0;
      end
      else if (!reset_any)
      begin
         reel_cnt_reg <= 32'h0000_0000;
         reel_done_reg <= 1'b0;
         REEL_CLEAR <= 1'b0;
      end
      else if (!reel_done_reg &&
         reel_cnt_reg >= REEL_HOLD_CYCLES - 32'd1)
      begin
         reel_done_reg <= 1'b1;
         REEL_CLEAR <= 1'b1;
      end
      else
      begin
         REEL_CLEAR <= 1'b0;
         if (!reel_done_reg)
            reel_cnt_reg <= reel_cnt_reg + 32'd1;
      end
   end
endmodule
`default_nettype wire

// ### dv/lilc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module lilc_asserts
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CFG_WR,
   input wire logic CFG_RD,
   input wire lilc_pkg::lilc_word_t CFG_RDATA,
   input wire logic CFG_ACK,
   input wire logic CFG_ERR,
   input wire logic [15:0] SPEED_IN,
   input wire logic [15:0] SPEED_OUT,
   input wire lilc_pkg::lilc_len_t LENGTH_OUT,
   input wire logic HOLD_ACTIVE,
   input wire logic RESET_ACTIVE,
   input wire logic REEL_CLEAR
);
   import lilc_pkg::*;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   AST_ACK: assert property ((CFG_WR || CFG_RD) |=> CFG_ACK)
      else $error("no ack");
   AST_ERR: assert property (CFG_ERR |-> CFG_ACK && !CFG_RDATA)
      else $error("bad err");
   AST_SPD0: assert property (HOLD_ACTIVE |-> !SPEED_OUT)
      else $error("speed not zero");
   AST_SPD: assert property
      (!HOLD_ACTIVE && $past(RST_N) |-> SPEED_OUT == $past(SPEED_IN))
      else $error("speed lost");
   // offset writes move the length legally, so they are excluded
   AST_FRZ: assert property (HOLD_ACTIVE &&
      $past(HOLD_ACTIVE) && !CFG_WR && !$past(CFG_WR) |=>
      $stable(LENGTH_OUT) || RESET_ACTIVE)
      else $error("length moved");
   AST_RCL: assert property (REEL_CLEAR |-> RESET_ACTIVE)
      else $error("stray reel");
   AST_RCP: assert property (REEL_CLEAR |=> !REEL_CLEAR)
      else $error("long reel");
   AST_RCE: assert property ($rose(RESET_ACTIVE) |->
      !REEL_CLEAR [*8])
      else $error("early reel");
endmodule
bind lilc_top lilc_asserts u_chk (.CLK, .RST_N, .CFG_WR, .CFG_RD,
   .CFG_RDATA, .CFG_ACK, .CFG_ERR, .SPEED_IN, .SPEED_OUT, .LENGTH_OUT,
   .HOLD_ACTIVE, .RESET_ACTIVE, .REEL_CLEAR);
`default_nettype wire

// ### dv/lilc_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module lilc_line_model
(
   input wire logic blk_up,
   input wire logic blk_dn,
   input wire logic rst_req,
   input wire logic open_rst,
   output logic pin_up,
   output logic pin_dn,
   output logic pin_rst
);
   // barriers pull low when clear, so hold must be active low
   assign pin_up = blk_up;
   assign pin_dn = blk_dn;
   // open pin floats to the pull-up
   assign pin_rst = open_rst | !rst_req;
endmodule
`default_nettype wire

// ### dv/lilc_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module lilc_top_tb_top;
   import lilc_pkg::*;
   logic CLK = 0, RST_N = 0, CFG_WR = 0, CFG_RD = 0, LEN_STEP = 0;
   logic [7:0] CFG_ADDR = 8'h00;
   lilc_word_t CFG_WDATA = 16'h0000, CFG_RDATA;
   logic CFG_ACK, CFG_ERR, HOLD_ACTIVE, RESET_ACTIVE, REEL_CLEAR;
   logic [15:0] SPEED_OUT;
   lilc_len_t LENGTH_OUT;
   logic p1, p2, p3, b1 = 1, b2 = 1, rq = 0, op = 0;
   logic dn = 0;
   logic [15:0] spd = 16'h1234;
   lilc_len_t len_fine;
   int fail_count = 0, n_checks = 0;
   lilc_top #(.REEL_HOLD_CYCLES(20)) DUT (.CLK, .RST_N,
      .FIRST_DIGITAL_IN(p1), .SECOND_DIGITAL_IN(p2), .THIRD_DIGITAL_IN(p3),
      .CFG_WR, .CFG_RD, .CFG_ADDR, .CFG_WDATA, .CFG_RDATA, .CFG_ACK,
      .CFG_ERR, .LEN_STEP, .LEN_STEP_DOWN(dn), .SPEED_IN(spd),
      .SPEED_OUT, .LENGTH_OUT, .HOLD_ACTIVE, .RESET_ACTIVE, .REEL_CLEAR);
   // factory fine-step build, fed the same stimulus
   lilc_top #(.REEL_HOLD_CYCLES(20), .FINE_OFFSET(1'b1)) DUT_FINE (.CLK,
      .RST_N, .FIRST_DIGITAL_IN(p1), .SECOND_DIGITAL_IN(p2),
      .THIRD_DIGITAL_IN(p3), .CFG_WR, .CFG_RD, .CFG_ADDR, .CFG_WDATA,
      .CFG_RDATA(), .CFG_ACK(), .CFG_ERR(), .LEN_STEP,
      .LEN_STEP_DOWN(dn), .SPEED_IN(spd), .SPEED_OUT(),
      .LENGTH_OUT(len_fine), .HOLD_ACTIVE(), .RESET_ACTIVE(),
      .REEL_CLEAR());
   lilc_line_model PM (.blk_up(b1), .blk_dn(b2), .rst_req(rq),
      .open_rst(op), .pin_up(p1), .pin_dn(p2), .pin_rst(p3));
   initial forever #12.5 CLK = !CLK;
   task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %s exp %h got %h", n, exp, got);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   task automatic io(logic w, logic [7:0] a, lilc_word_t d,
      lilc_word_t e, logic er);
      CFG_WR = w;
      CFG_RD = !w;
      CFG_ADDR = a;
      CFG_WDATA = d;
      cyc(1);
      CFG_WR = 0;
      CFG_RD = 0;
      chk("ack", CFG_ACK, 1);
      chk("err", CFG_ERR, er);
      if (!w) chk("rdata", CFG_RDATA, e);
      // gap so a strobe is never set twice in one step
      cyc(1);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic t_regs;
      io(0, 8'h0C, 16'h0000, 16'h0000, 0);
      io(0, 8'h0E, 16'h0000, 16'h0000, 0);
      io(1, 8'h0E, 16'h7FFF, 16'h0000, 0);
      io(0, 8'h0E, 16'h0000, 16'h7530, 0);
      io(1, 8'h0E, 16'h8000, 16'h0000, 0);
      io(0, 8'h0E, 16'h0000, 16'h8AD0, 0);
      io(1, 8'h0C, 16'hF411, 16'h0000, 0);
      io(0, 8'h0C, 16'h0000, 16'h0411, 0);
      io(0, 8'h10, 16'h0000, 16'h0000, 1);
      $display("regs done");
   endtask
   task automatic t_len;
      io(1, 8'h0E, 16'h000A, 16'h0000, 0);
      LEN_STEP = 1;
      cyc(3);
      dn = 1;
      cyc(1);
      LEN_STEP = 0;
      dn = 0;
      cyc(3);
      chk("len", LENGTH_OUT, 1002);
      chk("fine", len_fine, 12);
      io(1, 8'h0E, 16'hFFF6, 16'h0000, 0);
      cyc(3);
      chk("neg", LENGTH_OUT, -998);
      chk("fneg", len_fine, -8);
      b1 = 0;
      cyc(8);
      LEN_STEP = 1;
      cyc(2);
      LEN_STEP = 0;
      cyc(3);
      chk("hold", HOLD_ACTIVE, 1);
      chk("spd0", SPEED_OUT, 0);
      chk("frz", LENGTH_OUT, -998);
      b1 = 1;
      cyc(8);
      chk("spd", SPEED_OUT, 16'h1234);
      spd = 16'h00A5;
      cyc(1);
      chk("spd1", SPEED_OUT, 16'h00A5);
      $display("len done");
   endtask
   task automatic t_rst;
      int k;
      rq = 1;
      cyc(8);
      chk("ract", RESET_ACTIVE, 1);
      chk("clr", LENGTH_OUT, -1000);
      chk("fclr", len_fine, -10);
      k = 0;
      // a millisecond at 40 MHz keeps the pulse legal
      repeat (40000)
      begin
         if (REEL_CLEAR === 1'b1) k++;
         cyc(1);
      end
      rq = 0;
      chk("reel", k, 1);
      cyc(4);
      $display("rst done");
   endtask
   task automatic t_code;
      op = 1;
      io(1, 8'h0C, 16'h0C9A, 16'h0000, 0);
      cyc(8);
      chk("pol", HOLD_ACTIVE, 1);
      chk("open", RESET_ACTIVE, 1);
      b2 = 0;
      cyc(8);
      chk("none", HOLD_ACTIVE, 0);
      $display("code done");
   endtask
   task automatic t_rerun;
      RST_N = 0;
      cyc(2);
      RST_N = 1;
      cyc(1);
      chk("rhold", HOLD_ACTIVE, 0);
      chk("rlen", LENGTH_OUT, 0);
      io(0, 8'h0C, 16'h0000, 16'h0000, 0);
      io(0, 8'h0E, 16'h0000, 16'h0000, 0);
      $display("rerun done");
   endtask
   initial
   begin
      cyc(5);
      RST_N = 1;
      cyc(1);
      t_regs();
      t_len();
      t_rst();
      t_code();
      t_rerun();
      stop_test();
   end
endmodule
`default_nettype wire
